// ==== hw/lpdr_cfg.svh ====
// constants for the low-power supply drop reset block
// assumes inclusion by the package, lpdr_top and the bench
`ifndef LPDR_CFG_SVH
`define LPDR_CFG_SVH
// apb register byte offsets
`define LPDR_OFF_CFG 12'h000
`define LPDR_OFF_POWER_CONTROL_REGISTER 12'h004
`define LPDR_OFF_IRQ_STAT 12'h008
`define LPDR_OFF_IRQ_MASK 12'h00c
// configuration word two layout (14 bits)
`define LPDR_CFG_W 14
`define LPDR_CFG_ERASED 14'h3fff
`define LPDR_BIT_LPEN_N 11
// power control register bit of the shared drop cause flag
`define LPDR_BIT_CAUSE_N 0
// irq bit positions
`define LPDR_IRQ_DROP 0
`define LPDR_IRQ_REL 1
`define LPDR_IRQ_W 2
// power-up delay time
`define LPDR_PWRT_US 64
`define LPDR_CLK_MHZ 125
`endif

// ==== hw/lpdr_pkg.sv ====
// types shared by the low-power supply drop reset block
// assumes lpdr_cfg.svh sits on the include path
`include "lpdr_cfg.svh"
package lpdr_pkg;
    // reset sequencer states
    typedef enum logic [1:0] {
        LPDR_RUN = 2'b00,
        LPDR_HOLD = 2'b01,
        LPDR_DELAY = 2'b10
    } lpdr_state_e;
    // supply comparator view
    typedef struct packed {
        logic below;  // supply below low-power threshold
        logic main_rst;  // main detector asks for reset
    } lpdr_supply_s;
endpackage

// ==== hw/lpdr_delay.sv ====
// power-up delay counter for the low-power supply drop reset block
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module lpdr_delay #(
    parameter int COUNT = 8000  // cycles of the delay
) (
    input wire logic core_clk_i,  // system clock
    input wire logic reset_n_i,  // async reset, low
    input wire logic start_i,  // restart the count
    output logic done_o  // count has run out
);
    // ****************
    // counter
    // ****************
    logic [31:0] cnt_reg;  // remaining cycles
    logic [31:0] cnt_next;  // next remaining
    // a zero count would release at once and hide the supply settling time
    if (COUNT < 1) begin : g_bad_count
        $error("delay count must be positive");
    end
    // count down from the load value
    always_comb begin
        cnt_next = cnt_reg;
        if (start_i) begin
            cnt_next = 32'(COUNT);
        end else if (cnt_reg != 32'h0) begin
            cnt_next = cnt_reg - 32'h1;
        end
    end
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_reg <= 32'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    assign done_o = (cnt_reg == 32'h0) && !start_i;
endmodule  // lpdr_delay

// ==== hw/lpdr_top.sv ====
// low-power supply drop reset with config word, cause flag and irq
// assumes comparator outputs already synchronous to core_clk_i
//
// Summary of operation
// - hold device reset while supply below threshold
// - drop reset clears the active-low cause flag
// - one cause flag shared by both detectors
// - active-low config bit enables the detector
// - erased config word leaves detector disabled
// - power-up delay after every release, always on (no enable bit)
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "lpdr_cfg.svh"
module lpdr_top import lpdr_pkg::*; #(
    parameter int PWRT_CYCLES = `LPDR_PWRT_US * `LPDR_CLK_MHZ  // power-up delay
) (
    input wire logic core_clk_i,  // system clock 125 MHz
    input wire logic reset_n_i,  // async reset, low
    input wire logic low_power_drop_threshold_i,  // high: supply below threshold
    input wire logic main_drop_reset_i,  // main detector reset request
    input wire logic [`LPDR_CFG_W-1:0] cfg_word_i,  // configuration word two
    input wire logic cfg_load_i,  // pulse: config word valid
    input wire logic psel,  // apb select
    input wire logic penable,  // apb enable
    input wire logic pwrite,  // apb direction
    input wire logic [11:0] paddr,  // apb address
    input wire logic [31:0] pwdata,  // apb write data
    output logic [31:0] prdata,  // apb read data
    output logic pready,  // apb ready
    output logic pslverr,  // apb error
    output logic device_reset_o,  // device held in reset
    output logic irq_o  // interrupt level
);
    // ****************
    // state
    // ****************
    lpdr_state_e st_reg, st_next;  // sequencer state
    logic [`LPDR_CFG_W-1:0] cfg_reg, cfg_next;  // latched config word
    logic cause_n_reg, cause_n_next;  // shared drop cause flag
    logic [`LPDR_IRQ_W-1:0] stat_reg, stat_next;  // sticky events
    logic [`LPDR_IRQ_W-1:0] mask_reg, mask_next;  // irq mask
    logic rst_reg, rst_next;  // reset output
    logic irq_reg, irq_next;  // irq output
    logic [31:0] rd_reg, rd_next;  // read data
    logic rdy_reg, rdy_next;  // ready
    logic err_reg, err_next;  // error
    logic pwrt_done;  // delay ran out
    logic pwrt_start;  // restart delay
    logic lp_en;  // low-power detector enabled
    logic drop;  // any drop condition
    logic acc;  // apb access phase, first cycle
    logic wr;  // write lands at this edge, pready sampled high
    lpdr_supply_s sup;  // supply view
    assign sup = '{below: low_power_drop_threshold_i, main_rst: main_drop_reset_i};
    // a one disables; erased word is all ones so detector is off
    assign lp_en = !cfg_reg[`LPDR_BIT_LPEN_N];
    assign drop = (lp_en && sup.below) || sup.main_rst;
    assign acc = psel && penable && !rdy_reg;
    // the master samples pready high at this edge; only here may a write land
    assign wr = psel && penable && rdy_reg && pwrite;
    assign pwrt_start = (st_reg == LPDR_HOLD) && !drop;
    // address decode used for read and write
    function automatic logic [2:0] dec(input logic [11:0] a);
        if (a == `LPDR_OFF_CFG) dec = 3'h1;
        else if (a == `LPDR_OFF_POWER_CONTROL_REGISTER) dec = 3'h2;
        else if (a == `LPDR_OFF_IRQ_STAT) dec = 3'h3;
        else if (a == `LPDR_OFF_IRQ_MASK) dec = 3'h4;
        else dec = 3'h0;
    endfunction
    lpdr_delay #(.COUNT(PWRT_CYCLES)) u_delay (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .start_i(pwrt_start),
        .done_o(pwrt_done)
    );
    // ****************
    // sequencer and flags
    // ****************
    always_comb begin
        st_next = st_reg;
        cfg_next = cfg_load_i ? cfg_word_i : cfg_reg;
        cause_n_next = cause_n_reg;
        stat_next = stat_reg;
        mask_next = mask_reg;
        rd_next = rd_reg;
        rdy_next = acc;  // exactly one wait state, ready pulses one cycle
        err_next = 1'b0;  // error only ever stands beside ready
        // read data and error are chosen in the first access cycle so that
        // they stand together with pready at the edge the master samples
        if (acc) begin
            if (!pwrite) begin
                rd_next = 32'h0;  // unused bits read as zero
                if (dec(paddr) == 3'h1) begin
                    rd_next[`LPDR_CFG_W-1:0] = cfg_reg;  // config word
                end else if (dec(paddr) == 3'h2) begin
                    rd_next[`LPDR_BIT_CAUSE_N] = cause_n_reg;  // shared cause flag
                end else if (dec(paddr) == 3'h3) begin
                    rd_next[`LPDR_IRQ_W-1:0] = stat_reg;  // sticky events
                end else if (dec(paddr) == 3'h4) begin
                    rd_next[`LPDR_IRQ_W-1:0] = mask_reg;  // irq mask
                end else begin
                    err_next = 1'b1;  // unmapped read
                end
            end else if (dec(paddr) == 3'h0) begin
                err_next = 1'b1;  // unmapped write, dropped
            end
        end
        // software writes first, hardware events override below; the write
        // waits for the ready edge so that an aborted access changes nothing
        if (wr) begin
            if (dec(paddr) == 3'h2) begin
                cause_n_next = pwdata[`LPDR_BIT_CAUSE_N];
            end else if (dec(paddr) == 3'h3) begin
                stat_next = stat_reg & ~pwdata[`LPDR_IRQ_W-1:0];  // write one to clear
            end else if (dec(paddr) == 3'h4) begin
                mask_next = pwdata[`LPDR_IRQ_W-1:0];  // mask takes whole field
            end
            // the config word is read only: a write there is ignored
        end
        case (st_reg)
            LPDR_RUN: begin
                if (drop) begin
                    st_next = LPDR_HOLD;
                end
            end
            LPDR_HOLD: begin
                // release only once supply back above threshold
                if (!drop) begin
                    st_next = LPDR_DELAY;  // always settle through the delay
                end
            end
            LPDR_DELAY: begin
                if (drop) st_next = LPDR_HOLD;
                else if (pwrt_done) st_next = LPDR_RUN;
            end
            default: st_next = LPDR_HOLD;
        endcase
        // the word carries no delay enable bit, so the delay always runs;
        // a drop in the same cycle as a software write wins over it
        if (drop) begin
            cause_n_next = 1'b0;
            stat_next[`LPDR_IRQ_DROP] = 1'b1;
        end
        if (st_reg == LPDR_DELAY && st_next == LPDR_RUN) begin
            stat_next[`LPDR_IRQ_REL] = 1'b1;
        end
        rst_next = (st_next != LPDR_RUN);
        irq_next = |(stat_next & mask_next);
    end
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg <= LPDR_HOLD;
            cfg_reg <= `LPDR_CFG_ERASED;
            cause_n_reg <= 1'b1;
            stat_reg <= '0;
            mask_reg <= '0;
            rst_reg <= 1'b1;
            irq_reg <= 1'b0;
            rd_reg <= 32'h0;
            rdy_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cfg_reg <= cfg_next;
            cause_n_reg <= cause_n_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            rst_reg <= rst_next;
            irq_reg <= irq_next;
            rd_reg <= rd_next;
            rdy_reg <= rdy_next;
            err_reg <= err_next;
        end
    end
    assign prdata = rd_reg;
    assign pready = rdy_reg;
    assign pslverr = err_reg;
    assign device_reset_o = rst_reg;
    assign irq_o = irq_reg;
    // ****************
    // checks
    // ****************
    a_hold_while_low: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        drop |=> device_reset_o) else $error("reset not held during drop");
    a_cause_flag_set: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        drop |=> !cause_n_reg) else $error("cause flag not cleared on drop");
    a_shared_flag: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        sup.main_rst |=> !cause_n_reg) else $error("main drop missed shared flag");
    a_erased_off: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        cfg_reg[`LPDR_BIT_LPEN_N] && sup.below && !sup.main_rst |-> !drop)
        else $error("disabled detector acted");
    a_erased_reset: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        $rose(reset_n_i) |-> cfg_reg == `LPDR_CFG_ERASED) else $error("bad erased word");
    a_delay_held: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        $fell(drop) ##0 !drop[*2] |-> device_reset_o) else $error("released before delay");
    a_flag_sticky: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        !cause_n_reg && !wr |=> !cause_n_reg) else $error("flag lost");
    a_ready_pulse: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        pready |=> !pready) else $error("ready stood two cycles");
    a_err_ready: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        pslverr |-> pready) else $error("error without ready");
    a_release_event: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        st_reg == LPDR_DELAY && pwrt_done && !drop |=> !device_reset_o && stat_reg[`LPDR_IRQ_REL])
        else $error("release not recorded");
    a_irq_level: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        ##1 irq_o == |(stat_reg & mask_reg)) else $error("irq mismatch");
endmodule  // lpdr_top

// ==== verif/lpdr_top_tb_top.sv ====
// bench for the low-power supply drop reset block, driving apb and supply inputs
// assumes lpdr_cfg.svh on the include path and the design compiled before it
`timescale 1ns/1ps
`include "lpdr_cfg.svh"
module lpdr_top_tb_top;
    // ****
    // stimulus and checks
    // ****
    localparam int PWRT = 4;  // short power-up delay keeps the run brief
    logic core_clk_i = 1'b0;  // 125 MHz clock
    logic reset_n_i = 1'b0;  // async reset, low
    logic thr = 1'b0;  // supply below low-power threshold
    logic main_rst = 1'b0;  // main detector request, kept off unless tested
    logic [13:0] cfg_word_i = 14'h3fff;  // config word
    logic cfg_load_i = 1'b0;  // config strobe
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;  // apb controls
    logic [11:0] paddr = 12'h000;  // apb address
    logic [31:0] pwdata = 32'h0, prdata, rd;  // apb data
    logic pready, pslverr, device_reset_o, irq_o, er;  // design outputs
    int mismatches = 0, compares = 0, cycles = 0, n;  // bookkeeping
    lpdr_top #(.PWRT_CYCLES(PWRT)) i_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .low_power_drop_threshold_i(thr), .main_drop_reset_i(main_rst), .cfg_word_i(cfg_word_i),
        .cfg_load_i(cfg_load_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .device_reset_o(device_reset_o), .irq_o(irq_o));
    // clock and hang guard; the ceiling is far above the hundred or so cycles needed
    initial forever #4 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one apb transfer; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge core_clk_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge core_clk_i);
        penable <= 1'b1;
        do @(posedge core_clk_i); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask
    task automatic load(input logic [13:0] w);
        @(posedge core_clk_i);
        cfg_word_i <= w; cfg_load_i <= 1'b1;
        @(posedge core_clk_i);
        cfg_load_i <= 1'b0;
    endtask
    // bounded wait for the reset output to reach a level, counting cycles
    task automatic wait_rst(input logic lvl, input int lim);
        n = 0;
        while (device_reset_o !== lvl && n < lim) begin
            @(posedge core_clk_i);
            n++;
        end
        chk("device_reset_o", {31'h0, lvl}, {31'h0, device_reset_o});
    endtask
    task summarize;
        if (mismatches == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        wait_rst(1'b0, PWRT + 20);
        rdc(`LPDR_OFF_CFG, 32'h3fff, "cfg erased");
        rdc(`LPDR_OFF_POWER_CONTROL_REGISTER, 32'h1, "cause flag reset");
        apb(1'b1, `LPDR_OFF_CFG, 32'h0);  // read-only word ignores the write
        rdc(`LPDR_OFF_CFG, 32'h3fff, "cfg read only");
        apb(1'b1, `LPDR_OFF_IRQ_STAT, 32'h3);
        apb(1'b1, `LPDR_OFF_IRQ_MASK, 32'h0);
        thr <= 1'b1;  // erased part: detector off, no reset
        repeat (4) @(posedge core_clk_i);
        chk("no reset when erased", 32'h0, {31'h0, device_reset_o});
        thr <= 1'b0;
        load(14'h37ff);  // enable bit low, debugger bit kept one
        rdc(`LPDR_OFF_CFG, 32'h37ff, "cfg loaded");
        thr <= 1'b1;  // main detector stays off while low-power one is used
        wait_rst(1'b1, 3);
        rdc(`LPDR_OFF_POWER_CONTROL_REGISTER, 32'h0, "cause flag set");
        chk("irq masked", 32'h0, {31'h0, irq_o});
        thr <= 1'b0;
        wait_rst(1'b0, PWRT + 10);
        chk("release delay", 32'h1, {31'h0, n >= PWRT});
        rdc(`LPDR_OFF_POWER_CONTROL_REGISTER, 32'h0, "cause flag sticks");
        rdc(`LPDR_OFF_IRQ_STAT, 32'h3, "irq status");
        apb(1'b1, `LPDR_OFF_IRQ_MASK, 32'h3);
        @(posedge core_clk_i);
        chk("irq raised", 32'h1, {31'h0, irq_o});
        apb(1'b1, `LPDR_OFF_IRQ_STAT, 32'h3);
        @(posedge core_clk_i);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        apb(1'b1, `LPDR_OFF_POWER_CONTROL_REGISTER, 32'h1);
        rdc(`LPDR_OFF_POWER_CONTROL_REGISTER, 32'h1, "cause flag rearmed");
        main_rst <= 1'b1;  // main detector shares the same flag
        wait_rst(1'b1, 3);
        main_rst <= 1'b0;
        wait_rst(1'b0, PWRT + 10);
        rdc(`LPDR_OFF_POWER_CONTROL_REGISTER, 32'h0, "shared cause flag");
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        load(14'h3fff);  // disable bit high again
        thr <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        chk("no reset when disabled", 32'h0, {31'h0, device_reset_o});
        summarize();
    end
endmodule  // lpdr_top_tb_top
